//--- hdl/pes_pkg.sv
// shared constants for the precise event sampler
// assumes a 32-bit register bus with word-aligned byte offsets
package pes_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_EVENT_SELECTION_CONTROL_UP = 8'h00;
  localparam logic [7:0] OFS_EVENT_SELECTION_CONTROL_DN = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_SAVE_PTR = 8'h0C;
  localparam logic [7:0] OFS_MISC = 8'h10;
  localparam logic [7:0] OFS_FEATURE = 8'h14;
  localparam logic [7:0] OFS_BASE = 8'h18;
  localparam logic [7:0] OFS_INDEX = 8'h1C;
  localparam logic [7:0] OFS_ABS_MAX = 8'h20;
  localparam logic [7:0] OFS_THRESH = 8'h24;
  localparam logic [7:0] OFS_RELOAD = 8'h28;
  localparam logic [7:0] OFS_COUNT = 8'h2C;
  localparam logic [7:0] OFS_STATUS = 8'h30;
  // event selection control fields
  localparam int ESC_THREAD_ONE_USER_COUNT = 0;
  localparam int ESC_THREAD_ONE_KERNEL_COUNT = 1;
  localparam int ESC_THREAD_ZERO_USER_COUNT = 2;
  localparam int ESC_THREAD_ZERO_KERNEL_COUNT = 3;
  localparam int ESC_TAG_EN = 4;
  localparam int ESC_TAG_LSB = 5;
  localparam int ESC_MASK_LSB = 9;
  localparam int ESC_SEL_LSB = 25;
  // single-bit positions in other registers
  localparam int EN_SAMPLE_BIT = 24;
  localparam int FEAT_DS_BIT = 21;
  localparam int MISC_ABSENT_BIT = 12;
  localparam int STS_THR_BIT = 0;
  localparam int STS_FULL_BIT = 1;
  localparam int STS_BUSY_BIT = 2;
  // at-retirement event class codes
  localparam logic [5:0] CLS_FRONT_END = 6'h08;
  localparam logic [5:0] CLS_EXEC = 6'h0C;
  localparam logic [5:0] CLS_REPLAY = 6'h09;
  // all-ones counter value: next event overflows
  localparam logic [31:0] CNT_ALL_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] WORD_BYTES = 32'h00000004;
  // sampler sequencing
  typedef enum logic [0:0] {ST_COUNT, ST_STORE} pes_state_t;
endpackage : pes_pkg

//--- hdl/pes_qual.sv
// event qualifier for one event selection control register
// assumes retirement inputs are valid for one cycle per micro-op
`timescale 1ns/1ns
module pes_qual
  import pes_pkg::*;
#(
  parameter logic [15:0] TI_MASK = 16'h0000
)
(
  // selection register contents
  input wire logic [31:0] i_event_selection_control,
  // retiring micro-op
  input wire logic i_valid,
  input wire logic i_thread,
  input wire logic [1:0] i_cpl,
  input wire logic [5:0] i_class,
  input wire logic [15:0] i_events,
  input wire logic [3:0] i_tags,
  // results
  output logic o_hit,
  output logic o_tag_set,
  output logic [3:0] o_tag_val
);
  logic kernel; // privilege 0
  logic thr_ok; // thread and privilege qualify
  logic [15:0] mask;
  logic [5:0] sel;
  logic ev_ts; // thread-specific sub-event seen
  logic ev_ti; // thread-independent sub-event seen
  logic cls_ok;

  ////////////////////////////////////////////////////////////////////
  // qualification
  always_comb
  begin
    kernel = (i_cpl == 2'h0);
    mask = i_event_selection_control[ESC_MASK_LSB +: 16]; // [R20]
    sel = i_event_selection_control[ESC_SEL_LSB +: 6]; // [R21]
    if (i_thread)
      thr_ok = kernel ? i_event_selection_control[ESC_THREAD_ONE_KERNEL_COUNT] : i_event_selection_control[ESC_THREAD_ONE_USER_COUNT]; // [R14] [R15]
    else
      thr_ok = kernel ? i_event_selection_control[ESC_THREAD_ZERO_KERNEL_COUNT] : i_event_selection_control[ESC_THREAD_ZERO_USER_COUNT]; // [R16] [R17]
    // sub-events in TI_MASK ignore the thread bits
    ev_ts = |(mask & i_events & ~TI_MASK);
    ev_ti = |(mask & i_events & TI_MASK); // [R22]
    cls_ok = i_valid && (i_class == sel) && ((ev_ts && thr_ok) || ev_ti);
    // only the three at-retirement classes may feed sampling
    if (sel == CLS_EXEC)
      o_hit = i_valid && thr_ok && (|(mask[3:0] & i_tags)); // [R23]
    else if ((sel == CLS_FRONT_END) || (sel == CLS_REPLAY))
      o_hit = cls_ok; // [R5]
    else
      o_hit = 1'b0; // [R5]
    o_tag_set = i_event_selection_control[ESC_TAG_EN] && cls_ok; // [R18]
    o_tag_val = i_event_selection_control[ESC_TAG_LSB +: 4]; // [R19]
  end
endmodule : pes_qual

//--- hdl/pes_ahb.sv
// AHB-Lite slave front end: single word transfers, OKAY only
// assumes a single slave, so hready equals this hreadyout
`timescale 1ns/1ns
module pes_ahb
(
  // clock and synchronised reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // AHB-Lite slave side
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // register file side
  output logic o_wr,
  output logic [7:0] o_addr,
  output logic [31:0] o_wdata,
  input wire logic [31:0] i_rdata
);
  typedef struct packed {
    logic act; // data phase pending
    logic wr; // pending phase is a write
    logic rwait; // read data already captured
    logic [7:0] addr;
    logic [31:0] rdata;
  } pes_ahb_t;
  pes_ahb_t q;
  pes_ahb_t d;

  ////////////////////////////////////////////////////////////////////
  // next state: reads take one wait state so hrdata is a flop
  always_comb
  begin
    d = q;
    o_hreadyout = !(q.act && !q.wr && !q.rwait);
    if (q.act && !q.wr && !q.rwait)
    begin
      d.rdata = i_rdata;
      d.rwait = 1'b1;
    end
    if (i_hready)
    begin
      d.act = i_hsel && i_htrans[1];
      d.wr = i_hwrite;
      d.addr = i_haddr[7:0];
      d.rwait = 1'b0;
    end
  end

  // write strobe lands in the write data phase
  assign o_wr = q.act && q.wr;
  assign o_addr = q.addr;
  assign o_wdata = i_hwdata;
  assign o_hrdata = q.rdata;
  assign o_hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '0;
    else
      q <= d;
  end
endmodule : pes_ahb

//--- hdl/pes_sampler.sv
// precise event sampler: counts qualified retirement events,
// stores a state record on overflow and flags buffer threshold.
// assumes a word-wide memory write port that acknowledges each word.
//
// How it works
// R1: overflow stores registers, flags, pointer record
// R2: after store, reload counter and resume
// R3: raise interrupt at buffer threshold
// R4: buffer is linear, index never wraps
// R5: only three retirement classes, one counter
// R6: feature identify bit 21 shows debug store
// R7: sampling absent flag reads clear
// R8: enable bit 24 turns sampling on/off
// R9: save area pointer register locates management data
// R10: software programs buffer fields before enabling
// R11: one shared interrupt for all sampling sources
// R12: off on management mode, machine check; init clears
// R13: works in real address mode too
// R14: bit 0 counts thread one user
// R15: bit 1 counts thread one kernel
// R16: bit 2 counts thread zero user
// R17: bit 3 counts thread zero kernel
// R18: bit 4 enables micro-op tagging
// R19: bits 5-8 give the tag value
// R20: bits 9-24 select sub-events
// R21: bits 25-30 select event class
// R22: some sub-events ignore thread bits
// R23: execution class counts masked tag bits
// R24: advance index per record, stop at maximum
// R25: threshold compared against updated index
//
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module pes_sampler
  import pes_pkg::*;
#(
  parameter int NUM_GPR = 8,
  parameter logic [15:0] TI_MASK = 16'h0000
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // AHB-Lite register port
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // retiring micro-op
  input wire logic i_ret_valid,
  input wire logic i_ret_thread,
  input wire logic [1:0] i_ret_cpl,
  input wire logic [5:0] i_ret_class,
  input wire logic [15:0] i_ret_events,
  input wire logic [3:0] i_ret_tags,
  // architectural state to sample
  input wire logic [31:0] i_flags,
  input wire logic [31:0] i_ip,
  input wire logic [NUM_GPR*32-1:0] i_gpr,
  // processor mode events
  input wire logic i_smm_entry,
  input wire logic i_machine_check,
  input wire logic i_init,
  // other sources sharing the interrupt
  input wire logic i_nonprecise_irq,
  input wire logic i_branch_trace_irq,
  // record memory write port
  output logic o_mem_req,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_data,
  input wire logic i_mem_ack,
  // tagging and misc outputs
  output logic o_tag_set,
  output logic [3:0] o_tag_val,
  output logic [31:0] o_save_area_ptr,
  output logic o_irq
);
  localparam int REC_W = NUM_GPR + 2; // flags, pointer, registers
  localparam logic [3:0] LAST_WORD = 4'(REC_W - 1);
  localparam logic [31:0] REC_BYTES = 32'(REC_W * 4);

  // the word counter is four bits wide
  if (NUM_GPR < 1 || NUM_GPR > 14)
  begin : g_chk
    $error("NUM_GPR must be 1 to 14");
  end

  typedef struct packed {
    logic [31:0] event_selection_control_up; // tagging side selection
    logic [31:0] event_selection_control_dn; // counting side selection
    logic en; // sampling enable
    logic [31:0] save_ptr;
    logic [31:0] base;
    logic [31:0] index; // next record byte address
    logic [31:0] abs_max;
    logic [31:0] thresh;
    logic [31:0] reload;
    logic [31:0] count; // sampling counter
    pes_state_t st;
    logic [3:0] word; // word in flight
    logic [REC_W*32-1:0] snap; // captured state
    logic mem_req;
    logic [31:0] mem_addr;
    logic [31:0] mem_data;
    logic thr_hit; // sticky threshold flag
    logic irq;
  } pes_core_t;

  logic [1:0] rst_sync; // reset release chain
  logic rst_n;
  pes_core_t q;
  pes_core_t d;
  logic bus_wr;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic [31:0] rdata;
  logic cnt_hit; // counting qualifier fired
  logic full; // no room for another record
  logic [REC_W*32-1:0] arch; // live record image

  ////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////
  // register bus slave
  pes_ahb u_ahb (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hready(i_hready),
    .i_hwdata(i_hwdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .o_wr(bus_wr),
    .o_addr(bus_addr),
    .o_wdata(bus_wdata),
    .i_rdata(rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // qualifiers: upstream tags, downstream counts
  pes_qual #(.TI_MASK(TI_MASK)) u_up (
    .i_event_selection_control(q.event_selection_control_up),
    .i_valid(i_ret_valid),
    .i_thread(i_ret_thread),
    .i_cpl(i_ret_cpl),
    .i_class(i_ret_class),
    .i_events(i_ret_events),
    .i_tags(i_ret_tags),
    .o_hit(),
    .o_tag_set(o_tag_set),
    .o_tag_val(o_tag_val)
  );

  pes_qual #(.TI_MASK(TI_MASK)) u_dn (
    .i_event_selection_control(q.event_selection_control_dn),
    .i_valid(i_ret_valid),
    .i_thread(i_ret_thread),
    .i_cpl(i_ret_cpl),
    .i_class(i_ret_class),
    .i_events(i_ret_events),
    .i_tags(i_ret_tags),
    .o_hit(cnt_hit),
    .o_tag_set(),
    .o_tag_val()
  );

  ////////////////////////////////////////////////////////////////////
  // record image: flags, pointer, then registers; no mode gating,
  // so real address mode samples like any other [R13]
  assign arch = {i_gpr, i_ip, i_flags}; // [R1]
  // 33-bit sum so a high index cannot wrap past the limit
  assign full = ({1'b0, q.index} + {1'b0, REC_BYTES}) > {1'b0, q.abs_max}; // [R24]

  ////////////////////////////////////////////////////////////////////
  // register read mux; unmapped offsets read zero
  always_comb
  begin
    rdata = 32'h00000000;
    case (bus_addr)
      OFS_EVENT_SELECTION_CONTROL_UP: rdata = q.event_selection_control_up;
      OFS_EVENT_SELECTION_CONTROL_DN: rdata = q.event_selection_control_dn;
      OFS_ENABLE: rdata[EN_SAMPLE_BIT] = q.en;
      OFS_SAVE_PTR: rdata = q.save_ptr;
      OFS_MISC: rdata[MISC_ABSENT_BIT] = 1'b0; // [R7]
      OFS_FEATURE: rdata[FEAT_DS_BIT] = 1'b1; // [R6]
      OFS_BASE: rdata = q.base;
      OFS_INDEX: rdata = q.index;
      OFS_ABS_MAX: rdata = q.abs_max;
      OFS_THRESH: rdata = q.thresh;
      OFS_RELOAD: rdata = q.reload;
      OFS_COUNT: rdata = q.count;
      OFS_STATUS:
      begin
        rdata[STS_THR_BIT] = q.thr_hit;
        rdata[STS_FULL_BIT] = full;
        rdata[STS_BUSY_BIT] = (q.st == ST_STORE);
      end
      default: rdata = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // next state: software writes first, hardware updates after,
  // so a hardware set of the threshold flag beats a clear
  always_comb
  begin
    d = q;
    d.irq = i_nonprecise_irq || i_branch_trace_irq; // [R11]
    if (bus_wr)
    begin
      case (bus_addr)
        OFS_EVENT_SELECTION_CONTROL_UP: d.event_selection_control_up = bus_wdata;
        OFS_EVENT_SELECTION_CONTROL_DN: d.event_selection_control_dn = bus_wdata;
        OFS_ENABLE: d.en = bus_wdata[EN_SAMPLE_BIT]; // [R8]
        OFS_SAVE_PTR: d.save_ptr = bus_wdata; // [R9]
        OFS_BASE: d.base = bus_wdata;
        OFS_INDEX: d.index = bus_wdata;
        OFS_ABS_MAX: d.abs_max = bus_wdata;
        OFS_THRESH: d.thresh = bus_wdata;
        OFS_RELOAD: d.reload = bus_wdata;
        OFS_COUNT: d.count = bus_wdata;
        OFS_STATUS:
        begin
          if (bus_wdata[STS_THR_BIT])
            d.thr_hit = 1'b0;
        end
        default: d.thr_hit = d.thr_hit;
      endcase
    end
    unique case (q.st)
      ST_COUNT:
      begin
        if (q.en && cnt_hit)
        begin
          if (q.count == CNT_ALL_ONES)
          begin
            // overflow: reload at once, even when the buffer is full
            d.count = q.reload;
            if (!full)
            begin
              d.st = ST_STORE; // [R1]
              d.snap = arch;
              d.word = 4'h0;
              d.mem_req = 1'b1;
              d.mem_addr = q.index;
              d.mem_data = arch[31:0];
            end
          end
          else
            d.count = q.count + 32'h00000001;
        end
      end
      ST_STORE:
      begin
        // the counter holds while the record is written
        if (i_mem_ack)
        begin
          if (q.word == LAST_WORD)
          begin
            d.st = ST_COUNT;
            d.mem_req = 1'b0;
            d.count = q.reload; // [R2]
            d.index = q.index + REC_BYTES; // [R24] [R4]
            if (d.index >= q.thresh) // [R25]
            begin
              d.thr_hit = 1'b1; // [R3]
              d.irq = 1'b1; // [R11]
            end
          end
          else
          begin
            d.word = q.word + 4'h1;
            d.mem_addr = q.mem_addr + WORD_BYTES;
            d.mem_data = q.snap[32*(int'(q.word) + 1) +: 32];
          end
        end
      end
    endcase
    // a record already in flight is allowed to finish
    if (i_smm_entry || i_machine_check)
      d.en = 1'b0; // [R12]
    if (i_init)
      d = '0; // [R12]
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  assign o_mem_req = q.mem_req;
  assign o_mem_addr = q.mem_addr;
  assign o_mem_data = q.mem_data;
  assign o_save_area_ptr = q.save_ptr;
  assign o_irq = q.irq;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n || i_init);

  sequence ovf_seq;
    q.st == ST_COUNT && q.en && cnt_hit && q.count == CNT_ALL_ONES;
  endsequence

  sequence last_ack_seq;
    q.st == ST_STORE && i_mem_ack && q.word == LAST_WORD;
  endsequence

  overflow_store_a: assert property ( // [R1]
    ovf_seq and !full |=> o_mem_req && o_mem_addr == $past(q.index)
      && o_mem_data == $past(i_flags))
    else $error("overflow did not start a record");

  counter_reload_a: assert property ( // [R2]
    last_ack_seq |=> q.st == ST_COUNT && q.count == $past(q.reload))
    else $error("counter not reloaded after record");

  threshold_irq_a: assert property ( // [R3]
    last_ack_seq and (q.index + REC_BYTES >= q.thresh) |=> o_irq && q.thr_hit)
    else $error("threshold crossing gave no interrupt");

  index_linear_a: assert property ( // [R4]
    last_ack_seq |=> q.index == $past(q.index) + REC_BYTES)
    else $error("index did not advance by one record");

  full_stop_a: assert property ( // [R24]
    ovf_seq and full |=> !o_mem_req ##0 q.st == ST_COUNT)
    else $error("record stored past the maximum");

  enable_bit_a: assert property ( // [R8]
    bus_wr && bus_addr == OFS_ENABLE && !i_smm_entry && !i_machine_check
      |=> q.en == $past(bus_wdata[EN_SAMPLE_BIT]))
    else $error("enable bit not taken");

  mode_off_a: assert property ( // [R12]
    i_smm_entry || i_machine_check |=> !q.en)
    else $error("sampling stayed on after mode event");

  shared_irq_a: assert property ( // [R11]
    i_nonprecise_irq || i_branch_trace_irq |=> o_irq)
    else $error("shared interrupt source not passed");

  feature_bit_a: assert property ( // [R6]
    bus_addr == OFS_FEATURE |-> rdata[FEAT_DS_BIT] && !(rdata[MISC_ABSENT_BIT]))
    else $error("feature bit not reported");

  absent_flag_a: assert property ( // [R7]
    bus_addr == OFS_MISC |-> rdata == 32'h00000000)
    else $error("sampling absent flag set");

  disabled_idle_a: assert property ( // [R8]
    q.st == ST_COUNT && !q.en |=> $stable(q.count) || $past(bus_wr))
    else $error("counter moved while disabled");

  record_len_a: assert property ( // [R1]
    q.st == ST_STORE && !(i_mem_ack && q.word == LAST_WORD)
      |=> q.st == ST_STORE && o_mem_req)
    else $error("record aborted early");
endmodule : pes_sampler

//--- tb/pes_mem_model.sv
// record memory model: accepts record words from the sampler
// assumes the sampler holds req, addr and data until the ack edge
`timescale 1ns/1ns
module pes_mem_model
(
  // clock
  input wire logic i_clk,
  // word write port from the sampler
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_data,
  output logic o_ack,
  // cycles to wait before each ack, so slow memory is exercised
  input wire logic [1:0] i_delay
);
  ////////////////////////////////////////////////////////////////////////
  logic [31:0] mem [logic [31:0]]; // stored words by byte address
  int words = 0; // words accepted so far
  logic [1:0] wait_q = 2'h0; // cycles waited on the current word
  initial o_ack = 1'b0;
  // ack is a one-cycle pulse, raised only while a word is offered
  always @(posedge i_clk)
  begin
    if (o_ack)
    begin
      o_ack <= 1'b0;
      wait_q <= 2'h0;
    end
    else if (i_req && wait_q >= i_delay)
    begin
      // the word is taken as it stands when the ack is raised
      o_ack <= 1'b1;
      mem[i_addr] = i_data;
      words++;
    end
    else if (i_req)
      wait_q <= wait_q + 2'h1; // slow answer
  end
endmodule : pes_mem_model

//--- tb/testbench.sv
// bench for the precise event sampler: bus tasks plus call sequences
// assumes the design answers on AHB-Lite with hready fed back to it
`timescale 1ns/1ns
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  import pes_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  localparam int NG = 8; // saved general registers
  localparam int REC = (NG + 2) * 4; // record bytes
  localparam logic [31:0] BS = 32'h00001000; // buffer base
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hresp, mem_req, mem_ack, tag_set, irq;
  logic [31:0] hrdata, mem_addr, mem_data, save_ptr;
  logic [3:0] tag_val;
  logic rv = 1'b0; // retiring micro-op
  logic rt = 1'b0;
  logic [1:0] rc = 2'h0;
  logic [5:0] rk = 6'h0;
  logic [15:0] re = 16'h0;
  logic [3:0] rg = 4'h0;
  logic [4:0] pv = 5'h0; // smm, mce, init, non-precise, branch trace
  logic [1:0] mdelay = 2'h0;
  logic [NG*32-1:0] gpr;
  int fail_count = 0;
  int samples_checked = 0;
  int irq_count = 0;
  ////////////////////////////////////////////////////////////////////////
  pes_sampler #(.NUM_GPR(NG), .TI_MASK(16'h0002)) dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(1'b1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hready(hready), .i_hwdata(hwdata),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_ret_valid(rv), .i_ret_thread(rt), .i_ret_cpl(rc), .i_ret_class(rk),
    .i_ret_events(re), .i_ret_tags(rg), .i_flags(32'h00000246),
    .i_ip(32'h00401000), .i_gpr(gpr), .i_smm_entry(pv[0]),
    .i_machine_check(pv[1]), .i_init(pv[2]), .i_nonprecise_irq(pv[3]),
    .i_branch_trace_irq(pv[4]), .o_mem_req(mem_req), .o_mem_addr(mem_addr),
    .o_mem_data(mem_data), .i_mem_ack(mem_ack), .o_tag_set(tag_set),
    .o_tag_val(tag_val), .o_save_area_ptr(save_ptr), .o_irq(irq));
  pes_mem_model mem (.i_clk(i_clk), .i_req(mem_req), .i_addr(mem_addr),
    .i_data(mem_data), .o_ack(mem_ack), .i_delay(mdelay));
  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    forever #20 i_clk = ~i_clk;
  end
  // interrupt pulses are counted, not sampled, so none is missed
  always @(posedge i_clk)
    if (irq === 1'b1)
      irq_count++;
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compares %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // hready stands from one rising edge to the next, so the low phase shows it
  task automatic hwait;
    int n;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      fail_count++;
      stop_test();
    end
  endtask : hwait
  // one single-word transfer: address phase, then data phase
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
    output logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    hwait();
    @(posedge i_clk);
    htrans <= 2'b00;
    hwdata <= wd;
    hwait();
    @(posedge i_clk);
    d = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb(a, 1'b1, wd, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    ahb(a, 1'b0, 32'h0, d);
  endtask : rd
  // one retiring micro-op; the tag flag is sampled while it stands
  task automatic uop(input logic t, input logic [1:0] c, input logic [5:0] k,
    input logic [15:0] e, input logic [3:0] g, output logic ts);
    rv <= 1'b1;
    rt <= t;
    rc <= c;
    rk <= k;
    re <= e;
    rg <= g;
    @(negedge i_clk);
    ts = tag_set;
    @(posedge i_clk);
    rv <= 1'b0;
    @(posedge i_clk);
  endtask : uop
  // program the counting selection, retire one micro-op, compare the count
  task automatic tryc(input logic [31:0] s, input logic t, input logic [1:0] c,
    input logic [5:0] k, input logic [15:0] e, input logic [3:0] g,
    input logic x);
    logic [31:0] d;
    logic ts;
    wr(OFS_EVENT_SELECTION_CONTROL_DN, s);
    wr(OFS_COUNT, 32'h0);
    uop(t, c, k, e, g, ts);
    rd(OFS_COUNT, d);
    `CHK(d, {31'h0, x});
  endtask : tryc
  // a record is done once all its words are in and the request is gone
  task automatic wait_words(input int n);
    int k;
    k = 0;
    while ((mem.words != n || mem_req !== 1'b0) && k < 400)
    begin
      @(negedge i_clk);
      k++;
    end
    if (k >= 400)
    begin
      fail_count++;
      stop_test();
    end
    @(posedge i_clk);
  endtask : wait_words
  task automatic pulse(input logic [4:0] m);
    pv <= m;
    @(posedge i_clk);
    pv <= 5'h0;
    @(posedge i_clk);
  endtask : pulse
  function automatic logic [31:0] esc(logic [5:0] c, logic [15:0] m, logic [3:0] q);
    return {1'b0, c, m, 5'h0, q};
  endfunction : esc
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] d;
    logic ts;
    for (int k = 0; k < NG; k++)
      gpr[k*32+:32] = 32'hA0000000 + k;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    rd(OFS_FEATURE, d);
    `CHK(d[FEAT_DS_BIT], 1'b1);
    rd(OFS_MISC, d);
    `CHK(d[MISC_ABSENT_BIT], 1'b0);
    rd(8'h3C, d);
    `CHK(d, 32'h0);
    `CHK(hresp, 1'b0);
    wr(OFS_SAVE_PTR, 32'h00008000);
    rd(OFS_SAVE_PTR, d);
    `CHK(d, 32'h00008000);
    `CHK(save_ptr, 32'h00008000);
    // buffer fields first, then enable, then the counter
    wr(OFS_BASE, BS);
    wr(OFS_INDEX, BS);
    wr(OFS_ABS_MAX, BS + 3 * REC);
    wr(OFS_THRESH, BS + 2 * REC);
    wr(OFS_RELOAD, 32'hFFFFFFFE);
    wr(OFS_ENABLE, 32'h01000000);
    rd(OFS_ENABLE, d);
    `CHK(d[EN_SAMPLE_BIT], 1'b1);
    wr(OFS_EVENT_SELECTION_CONTROL_DN, esc(CLS_EXEC, 16'h0001, 4'hC));
    wr(OFS_COUNT, 32'hFFFFFFFE);
    // two hits overflow; the fourth overflow finds no room left
    for (int r = 0; r < 4; r++)
    begin
      mdelay <= 2'(r % 3);
      uop(1'b0, 2'h3, 6'h0, 16'h0, 4'h1, ts);
      uop(1'b0, 2'h0, 6'h0, 16'h0, 4'h1, ts);
      if (r < 3)
        wait_words((NG + 2) * (r + 1));
      else
        repeat (30) @(posedge i_clk);
      rd(OFS_INDEX, d);
      `CHK(d, BS + REC * (r < 3 ? r + 1 : 3));
      rd(OFS_COUNT, d);
      `CHK(d, 32'hFFFFFFFE);
      `CHK(mem.words, (NG + 2) * (r < 3 ? r + 1 : 3));
      `CHK(irq_count, r < 3 ? r : 2);
    end
    `CHK(mem.mem[BS], 32'h00000246);
    `CHK(mem.mem[BS + 4], 32'h00401000);
    for (int k = 0; k < NG; k++)
      `CHK(mem.mem[BS + 8 + 4 * k], 32'hA0000000 + k);
    rd(OFS_STATUS, d);
    `CHK(d[STS_THR_BIT], 1'b1);
    wr(OFS_STATUS, 32'h00000001);
    rd(OFS_STATUS, d);
    `CHK(d[STS_THR_BIT], 1'b0);
    // tagging from the upstream selection
    wr(OFS_EVENT_SELECTION_CONTROL_UP, esc(CLS_FRONT_END, 16'h0001, 4'hF) | 32'h000000B0);
    @(negedge i_clk);
    `CHK(tag_val, 4'h5);
    @(posedge i_clk);
    uop(1'b0, 2'h3, CLS_FRONT_END, 16'h0001, 4'h0, ts);
    `CHK(ts, 1'b1);
    wr(OFS_EVENT_SELECTION_CONTROL_UP, esc(CLS_FRONT_END, 16'h0001, 4'hF) | 32'h000000A0);
    uop(1'b0, 2'h3, CLS_FRONT_END, 16'h0001, 4'h0, ts);
    `CHK(ts, 1'b0);
    // every thread bit against both threads and kernel or user level
    for (int b = 0; b < 4; b++)
      for (int t = 0; t < 2; t++)
        for (int c = 0; c < 4; c += 3)
          tryc(esc(CLS_EXEC, 16'h0001, 4'(1 << b)), 1'(t), 2'(c), 6'h0, 16'h0, 4'h1,
            ((b >> 1) == 1 - t) && ((b % 2 == 1) == (c == 0)));
    tryc(esc(CLS_EXEC, 16'h0002, 4'hF), 0, 3, 6'h0, 16'h0, 4'h1, 0);
    tryc(esc(CLS_EXEC, 16'h0002, 4'hF), 0, 3, 6'h0, 16'h0, 4'h2, 1);
    tryc(esc(CLS_FRONT_END, 16'h0001, 4'hF), 0, 3, CLS_FRONT_END, 16'h1, 4'h0, 1);
    tryc(esc(CLS_FRONT_END, 16'h0001, 4'hF), 0, 3, CLS_FRONT_END, 16'h2, 4'h0, 0);
    tryc(esc(CLS_FRONT_END, 16'h0001, 4'hF), 0, 3, CLS_REPLAY, 16'h1, 4'h0, 0);
    tryc(esc(CLS_REPLAY, 16'h0001, 4'hF), 1, 0, CLS_REPLAY, 16'h1, 4'h0, 1);
    tryc(esc(6'h01, 16'h0001, 4'hF), 0, 3, 6'h01, 16'h1, 4'h0, 0);
    tryc(esc(CLS_FRONT_END, 16'h0002, 4'h0), 1, 3, CLS_FRONT_END, 16'h2, 4'h0, 1);
    tryc(esc(CLS_FRONT_END, 16'h0001, 4'h0), 1, 3, CLS_FRONT_END, 16'h1, 4'h0, 0);
    wr(OFS_ENABLE, 32'h0);
    tryc(esc(CLS_EXEC, 16'h0001, 4'hF), 0, 3, 6'h0, 16'h0, 4'h1, 0);
    // mode events drop the enable; shared interrupt sources; init
    for (int m = 0; m < 2; m++)
    begin
      wr(OFS_ENABLE, 32'h01000000);
      pulse(5'(1 << m));
      rd(OFS_ENABLE, d);
      `CHK(d[EN_SAMPLE_BIT], 1'b0);
    end
    pulse(5'h08);
    pulse(5'h10);
    rd(OFS_STATUS, d);
    `CHK(irq_count, 4);
    pulse(5'h04);
    rd(OFS_SAVE_PTR, d);
    `CHK(d, 32'h0);
    stop_test();
  end
endmodule : testbench
